/* hw/iorsd_pkg.sv */
// constants, operation codes and helpers for the i/o register space decoder
package iorsd_pkg;

   // address windows, in i/o and data-space terms
   localparam logic [7:0] IORSD_IO_LAST = 8'h3f;
   localparam logic [7:0] IORSD_BIT_LAST = 8'h1f;
   localparam logic [7:0] IORSD_DATA_OFS = 8'h20;
   localparam logic [7:0] IORSD_EXT_FIRST = 8'h60;
   localparam logic [7:0] IORSD_EXT_LAST = 8'hff;

   // port register triples: pin input, direction, output
   localparam logic [5:0] IORSD_OFS_PIN [4] = '{6'h00, 6'h03, 6'h06, 6'h09};
   localparam logic [5:0] IORSD_OFS_DIR [4] = '{6'h01, 6'h04, 6'h07, 6'h0a};
   localparam logic [5:0] IORSD_OFS_OUT [4] = '{6'h02, 6'h05, 6'h08, 6'h0b};

   // write-one-to-clear flag registers: timer0..3, pin change, external
   localparam logic [5:0] IORSD_OFS_FLAG [6] =
      '{6'h15, 6'h16, 6'h17, 6'h18, 6'h1b, 6'h1c};
   localparam logic [7:0] IORSD_MASK_FLAG [6] =
      '{8'h07, 8'h27, 8'h07, 8'h27, 8'h0f, 8'h07};

   localparam logic [5:0] IORSD_OFS_EXT_IRQ_MASK = 6'h1d;
   localparam logic [7:0] IORSD_MASK_EXT_IRQ = 8'h07;
   localparam logic [5:0] IORSD_OFS_SCRATCH0 = 6'h1e;
   localparam logic [5:0] IORSD_OFS_SCRATCH1 = 6'h2a;
   localparam logic [5:0] IORSD_OFS_SCRATCH2 = 6'h2b;
   localparam logic [5:0] IORSD_OFS_SP_LOW = 6'h3d;
   localparam logic [5:0] IORSD_OFS_SP_HIGH = 6'h3e;
   localparam logic [5:0] IORSD_OFS_STATUS = 6'h3f;

   localparam logic [7:0] IORSD_RST_BYTE = 8'h00;

   // core operations presented to the register space
   typedef enum logic [3:0] {
      IO_READ_OP,
      IO_WRITE_OP,
      SET_IO_BIT_OP,
      CLEAR_IO_BIT_OP,
      SKIP_IF_IO_BIT_SET_OP,
      SKIP_IF_IO_BIT_CLEAR_OP,
      INDIRECT_LOAD_OP,
      DIRECT_LOAD_OP,
      DISPLACED_LOAD_OP,
      INDIRECT_STORE_OP,
      DIRECT_STORE_OP,
      DISPLACED_STORE_OP
   } iorsd_op_e;

   // one-hot mask for a bit number
   function automatic logic [7:0] iorsd_bit_mask(input logic [2:0] b);
      iorsd_bit_mask = 8'h01 << b;
   endfunction : iorsd_bit_mask

   // true when a write strobe lands on a given i/o index
   function automatic logic iorsd_wr_sel(input logic en,
                                         input logic [5:0] idx,
                                         input logic [5:0] ofs);
      iorsd_wr_sel = en && (idx == ofs);
   endfunction : iorsd_wr_sel

endpackage : iorsd_pkg

/* hw/iorsd_acc_if.sv */
// decoded access carried from the address decoder to the register bank
`timescale 1ns/100ps
interface iorsd_acc_if;
   logic hit;
   logic rd;
   logic wr;
   logic set_bit;
   logic clr_bit;
   logic test_set;
   logic test_clr;
   logic [5:0] idx;

   modport decoder (output hit, rd, wr, set_bit, clr_bit, test_set,
                    test_clr, idx);
   modport bank (input hit, rd, wr, set_bit, clr_bit, test_set,
                 test_clr, idx);
endinterface : iorsd_acc_if

/* hw/iorsd_decode.sv */
// address decoder: i/o window, bit window and data-space mapping
`timescale 1ns/100ps
module iorsd_decode
   import iorsd_pkg::*;
(
   input wire logic core_req,
   input wire iorsd_op_e core_op,
   input wire logic [7:0] core_addr,
   iorsd_acc_if.decoder acc
);

   wire logic is_io_op;
   wire logic is_bit_op;
   wire logic is_load;
   wire logic is_store;
   wire logic io_ok;
   wire logic bit_ok;
   wire logic data_ok;
   wire logic [7:0] data_idx;

   // operation classes
   assign is_bit_op = (core_op == SET_IO_BIT_OP) ||
                      (core_op == CLEAR_IO_BIT_OP) ||
                      (core_op == SKIP_IF_IO_BIT_SET_OP) ||
                      (core_op == SKIP_IF_IO_BIT_CLEAR_OP);
   assign is_io_op = (core_op == IO_READ_OP) || (core_op == IO_WRITE_OP);
   assign is_load = (core_op == INDIRECT_LOAD_OP) ||
                    (core_op == DIRECT_LOAD_OP) ||
                    (core_op == DISPLACED_LOAD_OP);
   assign is_store = (core_op == INDIRECT_STORE_OP) ||
                     (core_op == DIRECT_STORE_OP) ||
                     (core_op == DISPLACED_STORE_OP);

   // window checks; the extended range has no register here and reads 0
   assign io_ok = is_io_op && (core_addr <= IORSD_IO_LAST);
   assign bit_ok = is_bit_op && (core_addr <= IORSD_BIT_LAST);
   assign data_ok = (is_load || is_store) &&
                    (core_addr >= IORSD_DATA_OFS) &&
                    (core_addr < IORSD_EXT_FIRST);
   assign data_idx = core_addr - IORSD_DATA_OFS;

   // decoded strobes
   assign acc.hit = core_req && (io_ok || bit_ok || data_ok);
   assign acc.idx = data_ok ? data_idx[5:0] : core_addr[5:0];
   assign acc.rd = acc.hit && ((core_op == IO_READ_OP) || is_load);
   assign acc.wr = acc.hit && ((core_op == IO_WRITE_OP) || is_store);
   assign acc.set_bit = acc.hit && (core_op == SET_IO_BIT_OP);
   assign acc.clr_bit = acc.hit && (core_op == CLEAR_IO_BIT_OP);
   assign acc.test_set = acc.hit &&
                         (core_op == SKIP_IF_IO_BIT_SET_OP);
   assign acc.test_clr = acc.hit &&
                         (core_op == SKIP_IF_IO_BIT_CLEAR_OP);

endmodule : iorsd_decode

/* hw/iorsd_flags.sv */
// one status flag register whose bits clear on a written one
`timescale 1ns/100ps
module iorsd_flags
   import iorsd_pkg::*;
#(
   parameter logic [7:0] VALID_MASK = 8'hff
)(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] set_pulse,
   input wire logic clr_en,
   input wire logic [7:0] clr_data,
   output logic [7:0] flags
);

   wire logic [7:0] clr_bits;
   wire logic [7:0] flags_next;

   // set is or-ed in after the clear so a same-cycle event survives
   assign clr_bits = clr_en ? clr_data : 8'h00;
   assign flags_next = ((flags & ~clr_bits) | set_pulse) & VALID_MASK;

   // reserved positions never hold a one
   always_ff @(posedge clk) begin
      if (!resetn) begin
         flags <= IORSD_RST_BYTE;
      end else begin
         flags <= flags_next;
      end
   end

endmodule : iorsd_flags

/* hw/iorsd_top.sv */
// low i/o register space: decode, bit access, port, flag and core registers
//
// How it works
// - bit set/clear only at 0x00-0x1f
// - bit test and skip only at 0x00-0x1f
// - flags clear on written one, zero keeps
// - bit ops rewrite whole register, clearing flags
// - i/o instructions reach indices 0x00-0x3f
// - data-space address is i/o index plus 0x20
// - 0x60-0xff holds no register; load/store there reads 0
// - pins float while reset is active
// - four 8-bit ports, per-bit pull-up
`timescale 1ns/100ps
module iorsd_top
   import iorsd_pkg::*;
#(
   parameter int NUM_PORTS = 4,
   parameter int NUM_FLAGS = 6
)(
   input wire logic clk,
   input wire logic resetn,
   input wire logic core_req,
   input wire iorsd_op_e core_op,
   input wire logic [7:0] core_addr,
   input wire logic [2:0] core_bit,
   input wire logic [7:0] core_wdata,
   output logic core_ack,
   output logic [7:0] core_rdata,
   output logic core_skip,
   input wire logic [NUM_PORTS-1:0][7:0] pin_in,
   output logic [NUM_PORTS-1:0][7:0] pin_out,
   output logic [NUM_PORTS-1:0][7:0] pin_oe,
   output logic [NUM_PORTS-1:0][7:0] pin_pullup,
   input wire logic [NUM_FLAGS-1:0][7:0] flag_set,
   output logic [7:0] ext_irq_mask,
   output logic [15:0] stack_pointer,
   output logic [7:0] core_status
);

   iorsd_acc_if acc ();

   logic [7:0] io_space [64];
   logic [NUM_PORTS-1:0][7:0] dir_reg;
   logic [NUM_PORTS-1:0][7:0] out_reg;
   logic [NUM_PORTS-1:0][7:0] pin_sample_reg;
   logic [NUM_FLAGS-1:0][7:0] flag_q;
   logic [7:0] external_irq_mask_reg;
   logic [7:0] scratch0_reg;
   logic [7:0] scratch1_reg;
   logic [7:0] scratch2_reg;
   logic [7:0] sp_low_reg;
   logic [7:0] sp_high_reg;
   logic [7:0] status_reg;
   logic ack_reg;
   logic [7:0] rdata_reg;
   logic skip_reg;
   wire logic [7:0] cur;
   wire logic [7:0] bmask;
   wire logic [7:0] wr_data;
   wire logic wr_any;
   wire logic [7:0] rdata_next;
   wire logic skip_next;

   iorsd_decode u_decode (
      .core_req (core_req),
      .core_op (core_op),
      .core_addr (core_addr),
      .acc (acc)
   );

   // read view of the 64 i/o locations; unlisted ones stay zero
   always_comb begin
      io_space = '{default: 8'h00};
      for (int p = 0; p < NUM_PORTS; p++) begin
         io_space[IORSD_OFS_PIN[p]] = pin_sample_reg[p];
         io_space[IORSD_OFS_DIR[p]] = dir_reg[p];
         io_space[IORSD_OFS_OUT[p]] = out_reg[p];
      end
      for (int f = 0; f < NUM_FLAGS; f++) begin
         io_space[IORSD_OFS_FLAG[f]] = flag_q[f];
      end
      io_space[IORSD_OFS_EXT_IRQ_MASK] = external_irq_mask_reg;
      io_space[IORSD_OFS_SCRATCH0] = scratch0_reg;
      io_space[IORSD_OFS_SCRATCH1] = scratch1_reg;
      io_space[IORSD_OFS_SCRATCH2] = scratch2_reg;
      io_space[IORSD_OFS_SP_LOW] = sp_low_reg;
      io_space[IORSD_OFS_SP_HIGH] = sp_high_reg;
      io_space[IORSD_OFS_STATUS] = status_reg;
   end

   // bit ops modify the full byte read back, so set flags go back as ones
   assign cur = io_space[acc.idx];
   assign bmask = iorsd_bit_mask(core_bit);
   assign wr_data = acc.set_bit ? (cur | bmask) :
                    acc.clr_bit ? (cur & ~bmask) : core_wdata;
   assign wr_any = acc.wr || acc.set_bit || acc.clr_bit;
   assign rdata_next = acc.rd ? cur : 8'h00;
   assign skip_next = acc.test_set ? cur[core_bit] :
                      acc.test_clr ? !cur[core_bit] : 1'b0;

   // port registers; pin input locations are read-only samples
   generate
      for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
         always_ff @(posedge clk) begin
            if (!resetn) begin
               dir_reg[p] <= IORSD_RST_BYTE;
            end else if (iorsd_wr_sel(wr_any, acc.idx, IORSD_OFS_DIR[p])) begin
               dir_reg[p] <= wr_data;
            end
         end
         always_ff @(posedge clk) begin
            if (!resetn) begin
               out_reg[p] <= IORSD_RST_BYTE;
            end else if (iorsd_wr_sel(wr_any, acc.idx, IORSD_OFS_OUT[p])) begin
               out_reg[p] <= wr_data;
            end
         end
         always_ff @(posedge clk) begin
            if (!resetn) begin
               pin_sample_reg[p] <= IORSD_RST_BYTE;
            end else begin
               pin_sample_reg[p] <= pin_in[p];
            end
         end
      end
   endgenerate

   // status flags, fed by the peripheral set pulses
   generate
      for (genvar f = 0; f < NUM_FLAGS; f++) begin : g_flag
         iorsd_flags #(
            .VALID_MASK (IORSD_MASK_FLAG[f])
         ) u_flags (
            .clk (clk),
            .resetn (resetn),
            .set_pulse (flag_set[f]),
            .clr_en (iorsd_wr_sel(wr_any, acc.idx, IORSD_OFS_FLAG[f])),
            .clr_data (wr_data),
            .flags (flag_q[f])
         );
      end
   endgenerate

   // external interrupt mask keeps only its three live bits
   always_ff @(posedge clk) begin
      if (!resetn) begin
         external_irq_mask_reg <= IORSD_RST_BYTE;
      end else if (iorsd_wr_sel(wr_any, acc.idx, IORSD_OFS_EXT_IRQ_MASK)) begin
         external_irq_mask_reg <= wr_data & IORSD_MASK_EXT_IRQ;
      end
   end

   // scratch bytes; only the first sits inside the bit window
   always_ff @(posedge clk) begin
      if (!resetn) begin
         scratch0_reg <= IORSD_RST_BYTE;
         scratch1_reg <= IORSD_RST_BYTE;
         scratch2_reg <= IORSD_RST_BYTE;
      end else begin
         if (iorsd_wr_sel(wr_any, acc.idx, IORSD_OFS_SCRATCH0)) begin
            scratch0_reg <= wr_data;
         end
         if (iorsd_wr_sel(wr_any, acc.idx, IORSD_OFS_SCRATCH1)) begin
            scratch1_reg <= wr_data;
         end
         if (iorsd_wr_sel(wr_any, acc.idx, IORSD_OFS_SCRATCH2)) begin
            scratch2_reg <= wr_data;
         end
      end
   end

   // stack pointer halves and core status, top of the i/o window
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sp_low_reg <= IORSD_RST_BYTE;
         sp_high_reg <= IORSD_RST_BYTE;
         status_reg <= IORSD_RST_BYTE;
      end else begin
         if (iorsd_wr_sel(wr_any, acc.idx, IORSD_OFS_SP_LOW)) begin
            sp_low_reg <= wr_data;
         end
         if (iorsd_wr_sel(wr_any, acc.idx, IORSD_OFS_SP_HIGH)) begin
            sp_high_reg <= wr_data;
         end
         if (iorsd_wr_sel(wr_any, acc.idx, IORSD_OFS_STATUS)) begin
            status_reg <= wr_data;
         end
      end
   end

   // answer registered one edge after the request
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack_reg <= 1'b0;
         rdata_reg <= IORSD_RST_BYTE;
         skip_reg <= 1'b0;
      end else begin
         ack_reg <= core_req;
         rdata_reg <= rdata_next;
         skip_reg <= skip_next;
      end
   end

   assign core_ack = ack_reg;
   assign core_rdata = rdata_reg;
   assign core_skip = skip_reg;
   assign pin_out = out_reg;
   assign ext_irq_mask = external_irq_mask_reg;
   assign stack_pointer = {sp_high_reg, sp_low_reg};
   assign core_status = status_reg;

   // reset gates the drivers with no clock needed, so pins float at once
   assign pin_oe = dir_reg & {(NUM_PORTS*8){resetn}};
   // pull-up where a bit is input and its output latch holds one
   assign pin_pullup = ~dir_reg & out_reg &
                       {(NUM_PORTS*8){resetn}};

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   always_comb begin
      a_reset_pins_float: assert (resetn ||
                                  (pin_oe == '0 && pin_pullup == '0))
         else $error("pins driven or pulled during reset");
   end

   a_answer_next_cycle: assert property (
      core_req |=> core_ack ##1 (core_ack == $past(core_req)))
      else $error("access not answered on the next edge");

   a_skip_follows_bit: assert property (
      (core_req && core_op == SKIP_IF_IO_BIT_SET_OP &&
       core_addr <= IORSD_BIT_LAST)
      |=> core_skip == $past(cur[core_bit]))
      else $error("skip does not follow tested bit");

   a_no_bit_above: assert property (
      (core_req && core_addr > IORSD_BIT_LAST &&
       (core_op == SKIP_IF_IO_BIT_CLEAR_OP ||
        core_op == SET_IO_BIT_OP))
      |=> !core_skip && $stable(status_reg) && $stable(sp_low_reg))
      else $error("bit operation acted above the bit window");

   a_flag_w1c: assert property (
      (core_req && core_op == IO_WRITE_OP &&
       core_addr == {2'b00, IORSD_OFS_FLAG[0]})
      |=> flag_q[0] == ((($past(flag_q[0]) & ~$past(core_wdata)) |
                         $past(flag_set[0])) & IORSD_MASK_FLAG[0]))
      else $error("flag write did not clear on ones only");

   a_rmw_clears_flags: assert property (
      (core_req && core_op == SET_IO_BIT_OP &&
       core_addr == {2'b00, IORSD_OFS_FLAG[1]})
      |=> flag_q[1] == ($past(flag_set[1]) & IORSD_MASK_FLAG[1]))
      else $error("bit set left a read-as-one flag standing");

   a_data_alias: assert property (
      (core_req && core_op == DIRECT_STORE_OP &&
       core_addr == ({2'b00, IORSD_OFS_SCRATCH1} + IORSD_DATA_OFS))
      |=> scratch1_reg == $past(core_wdata))
      else $error("mapped store missed its i/o register");

   a_ext_reads_zero: assert property (
      (core_req && core_op == DISPLACED_LOAD_OP &&
       core_addr >= IORSD_EXT_FIRST)
      |=> core_ack && core_rdata == 8'h00)
      else $error("extended range load returned data");

   a_io_window_write: assert property (
      (core_req && core_op == IO_WRITE_OP &&
       core_addr == {2'b00, IORSD_OFS_STATUS})
      |=> core_status == $past(core_wdata))
      else $error("i/o write to status register lost");

   a_reserved_zero: assert property (
      (core_req && core_op == IO_READ_OP &&
       core_addr == {2'b00, IORSD_OFS_FLAG[2]} + 8'h02)
      |=> core_rdata == 8'h00 && (ext_irq_mask & ~IORSD_MASK_EXT_IRQ) == 0)
      else $error("reserved location or bit read non-zero");

   // the inverted test must mirror the set test bit for bit
   a_skip_clear_bit: assert property (
      (core_req && core_op == SKIP_IF_IO_BIT_CLEAR_OP &&
       core_addr <= IORSD_BIT_LAST)
      |=> core_skip == !$past(cur[core_bit]))
      else $error("skip does not follow cleared bit");

   // a bit set on a plain latch keeps every other bit of the byte
   a_set_bit_latch: assert property (
      (core_req && core_op == SET_IO_BIT_OP &&
       core_addr == {2'b00, IORSD_OFS_OUT[0]})
      |=> pin_out[0] == ($past(pin_out[0]) | (8'h01 << $past(core_bit))))
      else $error("bit set did not land in the output latch");

   // no request, no answer: a stale ack would retire a phantom access
   a_quiet_no_ack: assert property (
      !core_req |=> !core_ack && core_rdata == 8'h00 && !core_skip)
      else $error("answer given without a request");

endmodule : iorsd_top

/* verif/iorsd_core_model.sv */
// processor core model issuing i/o, bit and load/store accesses
`timescale 1ns/100ps
module iorsd_core_model
   import iorsd_pkg::*;
(
   input wire logic clk,
   output logic core_req,
   output iorsd_op_e core_op,
   output logic [7:0] core_addr,
   output logic [2:0] core_bit,
   output logic [7:0] core_wdata,
   input wire logic core_ack,
   input wire logic [7:0] core_rdata,
   input wire logic core_skip
);

   // quiet bus until the first access
   initial begin
      core_req = 1'b0;
      core_op = IO_READ_OP;
      core_addr = 8'h00;
      core_bit = 3'h0;
      core_wdata = 8'h00;
   end

   // one access, entered at a falling edge; the request stays up so
   // accesses can run back to back; data is sent exactly as the caller
   // chose it, reserved bits and addresses included
   task automatic access(input iorsd_op_e op, input logic [7:0] addr,
                         input logic [2:0] b, input logic [7:0] wd,
                         output logic ack, output logic [7:0] rd,
                         output logic sk);
      core_req = 1'b1;
      core_op = op;
      core_addr = addr;
      core_bit = b;
      core_wdata = wd;
      @(negedge clk);
      ack = core_ack;
      rd = core_rdata;
      sk = core_skip;
   endtask : access

   // drop the request for one cycle; address shows garbage, not old value
   task automatic idle();
      core_req = 1'b0;
      core_addr = ~core_addr;
      core_wdata = ~core_wdata;
      @(negedge clk);
   endtask : idle

endmodule : iorsd_core_model

/* verif/iorsd_top_tb.sv */
// self-checking bench for the low i/o register space
`timescale 1ns/100ps
module iorsd_top_tb;
   import iorsd_pkg::*;

   typedef struct {
      iorsd_op_e op;
      logic [7:0] addr;
      logic [2:0] b;
      logic [7:0] wd;
      logic [7:0] rd;
      logic sk;
   } iorsd_row_s;

   logic clk;
   logic resetn;
   logic core_req;
   iorsd_op_e core_op;
   logic [7:0] core_addr;
   logic [2:0] core_bit;
   logic [7:0] core_wdata;
   logic core_ack;
   logic [7:0] core_rdata;
   logic core_skip;
   logic [3:0][7:0] pin_in;
   logic [3:0][7:0] pin_out;
   logic [3:0][7:0] pin_oe;
   logic [3:0][7:0] pin_pullup;
   logic [5:0][7:0] flag_set;
   logic [7:0] ext_irq_mask;
   logic [15:0] stack_pointer;
   logic [7:0] core_status;
   int error_cnt;
   int n_tests;
   int cyc;
   iorsd_row_s rows [32];

   iorsd_top u_iorsd_top (.clk(clk), .resetn(resetn), .core_req(core_req),
      .core_op(core_op), .core_addr(core_addr), .core_bit(core_bit),
      .core_wdata(core_wdata), .core_ack(core_ack), .core_rdata(core_rdata),
      .core_skip(core_skip), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_pullup(pin_pullup), .flag_set(flag_set),
      .ext_irq_mask(ext_irq_mask), .stack_pointer(stack_pointer),
      .core_status(core_status));

   iorsd_core_model u_iorsd_core_model (.clk(clk), .core_req(core_req),
      .core_op(core_op), .core_addr(core_addr), .core_bit(core_bit),
      .core_wdata(core_wdata), .core_ack(core_ack), .core_rdata(core_rdata),
      .core_skip(core_skip));

   // clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input string name, input logic [15:0] exp,
                        input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // one access with its one-cycle answer checked
   task automatic io(input iorsd_op_e op, input logic [7:0] addr,
                     input logic [2:0] b, input logic [7:0] wd,
                     input logic [7:0] erd, input logic esk);
      logic ack;
      logic [7:0] rd;
      logic sk;
      u_iorsd_core_model.access(op, addr, b, wd, ack, rd, sk);
      check("ack", 16'h0001, {15'h0, ack});
      check("rdata", {8'h00, erd}, {8'h00, rd});
      check("skip", {15'h0, esk}, {15'h0, sk});
   endtask : io

   task automatic check_cleared();
      check("ack", 16'h0000, {15'h0, core_ack});
      check("rdata", 16'h0000, {8'h00, core_rdata});
      check("skip", 16'h0000, {15'h0, core_skip});
      check("status", 16'h0000, {8'h00, core_status});
      check("sp", 16'h0000, stack_pointer);
      check("eimask", 16'h0000, {8'h00, ext_irq_mask});
      check("pout", 16'h0000, {8'h00, pin_out[0]});
   endtask : check_cleared

   task automatic results();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   // hang guard: the whole run needs about 110 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         $display("mismatch timeout expected done seen running");
         results();
      end
   end

   initial begin
      resetn = 1'b0;
      pin_in = '0;
      flag_set = '0;
      // reserved bits written as zero; one i/o write goes to 0x5f, above the i/o window
      rows = '{
         '{IO_WRITE_OP, 8'h3f, 3'h0, 8'h5a, 8'h00, 1'b0},
         '{DIRECT_LOAD_OP, 8'h5f, 3'h0, 8'h00, 8'h5a, 1'b0},
         '{INDIRECT_STORE_OP, 8'h5e, 3'h0, 8'h12, 8'h00, 1'b0},
         '{IO_READ_OP, 8'h3e, 3'h0, 8'h00, 8'h12, 1'b0},
         '{DISPLACED_STORE_OP, 8'h5d, 3'h0, 8'h34, 8'h00, 1'b0},
         '{INDIRECT_LOAD_OP, 8'h5d, 3'h0, 8'h00, 8'h34, 1'b0},
         '{DIRECT_STORE_OP, 8'h4a, 3'h0, 8'h77, 8'h00, 1'b0},
         '{IO_READ_OP, 8'h2a, 3'h0, 8'h00, 8'h77, 1'b0},
         '{IO_WRITE_OP, 8'h2b, 3'h0, 8'hc3, 8'h00, 1'b0},
         '{DISPLACED_LOAD_OP, 8'h4b, 3'h0, 8'h00, 8'hc3, 1'b0},
         '{IO_WRITE_OP, 8'h02, 3'h0, 8'ha5, 8'h00, 1'b0},
         '{SET_IO_BIT_OP, 8'h02, 3'h1, 8'h00, 8'h00, 1'b0},
         '{IO_READ_OP, 8'h02, 3'h0, 8'h00, 8'ha7, 1'b0},
         '{CLEAR_IO_BIT_OP, 8'h02, 3'h0, 8'h00, 8'h00, 1'b0},
         '{IO_READ_OP, 8'h02, 3'h0, 8'h00, 8'ha6, 1'b0},
         '{SKIP_IF_IO_BIT_SET_OP, 8'h02, 3'h7, 8'h00, 8'h00, 1'b1},
         '{SKIP_IF_IO_BIT_SET_OP, 8'h02, 3'h0, 8'h00, 8'h00, 1'b0},
         '{SKIP_IF_IO_BIT_CLEAR_OP, 8'h02, 3'h0, 8'h00, 8'h00, 1'b1},
         '{SKIP_IF_IO_BIT_CLEAR_OP, 8'h02, 3'h1, 8'h00, 8'h00, 1'b0},
         '{SET_IO_BIT_OP, 8'h2a, 3'h0, 8'h00, 8'h00, 1'b0},
         '{IO_READ_OP, 8'h2a, 3'h0, 8'h00, 8'h77, 1'b0},
         '{SKIP_IF_IO_BIT_SET_OP, 8'h3f, 3'h6, 8'h00, 8'h00, 1'b0},
         '{IO_READ_OP, 8'h40, 3'h0, 8'h00, 8'h00, 1'b0},
         '{IO_WRITE_OP, 8'h5f, 3'h0, 8'hff, 8'h00, 1'b0},
         '{IO_READ_OP, 8'h3f, 3'h0, 8'h00, 8'h5a, 1'b0},
         '{DIRECT_LOAD_OP, 8'h1f, 3'h0, 8'h00, 8'h00, 1'b0},
         '{DIRECT_LOAD_OP, 8'h60, 3'h0, 8'h00, 8'h00, 1'b0},
         '{IO_READ_OP, 8'h0c, 3'h0, 8'h00, 8'h00, 1'b0},
         '{IO_WRITE_OP, 8'h1d, 3'h0, 8'h05, 8'h00, 1'b0},
         '{DIRECT_LOAD_OP, 8'h3d, 3'h0, 8'h00, 8'h05, 1'b0},
         '{IO_READ_OP, 8'h19, 3'h0, 8'h00, 8'h00, 1'b0},
         '{DISPLACED_LOAD_OP, 8'hff, 3'h0, 8'h00, 8'h00, 1'b0}};
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      check_cleared();
      @(negedge clk);
      // ordinary cases, back to back with no idle cycle between
      foreach (rows[i])
         io(rows[i].op, rows[i].addr, rows[i].b, rows[i].wd, rows[i].rd,
            rows[i].sk);
      u_iorsd_core_model.idle();
      check("status", 16'h005a, {8'h00, core_status});
      check("sp", 16'h1234, stack_pointer);
      check("eimask", 16'h0005, {8'h00, ext_irq_mask});
      check("ack_idle", 16'h0000, {15'h0, core_ack});
      // port a drives low nibble; pull-ups only on undriven high bits
      io(IO_WRITE_OP, 8'h01, 3'h0, 8'h0f, 8'h00, 1'b0);
      u_iorsd_core_model.idle();
      check("oe", 16'h000f, {8'h00, pin_oe[0]});
      check("out", 16'h00a6, {8'h00, pin_out[0]});
      check("pullup", 16'h00a0, {8'h00, pin_pullup[0]});
      // ports b..d have latches of their own
      for (int p = 1; p < 4; p++) begin
         io(IO_WRITE_OP, {2'b00, IORSD_OFS_DIR[p]}, 3'h0, 8'hc3, 8'h00,
            1'b0);
         io(IO_WRITE_OP, {2'b00, IORSD_OFS_OUT[p]}, 3'h0, 8'h5a, 8'h00,
            1'b0);
         u_iorsd_core_model.idle();
         check("oe_p", 16'h00c3, {8'h00, pin_oe[p]});
         check("out_p", 16'h005a, {8'h00, pin_out[p]});
         check("pu_p", 16'h0018, {8'h00, pin_pullup[p]});
      end
      // pin input is read-only and lags the pins by one register
      pin_in[1] = 8'h3c;
      repeat (2) @(negedge clk);
      io(IO_READ_OP, 8'h03, 3'h0, 8'h00, 8'h3c, 1'b0);
      io(IO_WRITE_OP, 8'h03, 3'h0, 8'hff, 8'h00, 1'b0);
      io(IO_READ_OP, 8'h03, 3'h0, 8'h00, 8'h3c, 1'b0);
      io(SKIP_IF_IO_BIT_SET_OP, 8'h03, 3'h2, 8'h00, 8'h00, 1'b1);
      // every flag register: set all, clear by one, keep on zero, then a
      // bit op on an unrelated bit wipes every flag that read as one
      for (int i = 0; i < 6; i++) begin
         iorsd_op_e rmw_op;
         // odd registers take a bit set, even ones a bit clear
         if (i[0]) begin
            rmw_op = SET_IO_BIT_OP;
         end else begin
            rmw_op = CLEAR_IO_BIT_OP;
         end
         flag_set[i] = 8'hff;
         @(negedge clk);
         flag_set[i] = 8'h00;
         io(IO_READ_OP, {2'b00, IORSD_OFS_FLAG[i]}, 3'h0, 8'h00,
            IORSD_MASK_FLAG[i], 1'b0);
         io(IO_WRITE_OP, {2'b00, IORSD_OFS_FLAG[i]}, 3'h0, 8'h01, 8'h00,
            1'b0);
         io(IO_WRITE_OP, {2'b00, IORSD_OFS_FLAG[i]}, 3'h0, 8'h00, 8'h00,
            1'b0);
         io(IO_READ_OP, {2'b00, IORSD_OFS_FLAG[i]}, 3'h0, 8'h00,
            IORSD_MASK_FLAG[i] & 8'hfe, 1'b0);
         io(rmw_op, {2'b00, IORSD_OFS_FLAG[i]}, 3'h7, 8'h00, 8'h00,
            1'b0);
         io(IO_READ_OP, {2'b00, IORSD_OFS_FLAG[i]}, 3'h0, 8'h00, 8'h00,
            1'b0);
      end
      u_iorsd_core_model.idle();
      // mid-run reset: pins must float before any clock edge
      resetn = 1'b0;
      #1;
      check("oe_rst", 16'h0000, {15'h0, |pin_oe});
      check("pu_rst", 16'h0000, {15'h0, |pin_pullup});
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      check_cleared();
      @(negedge clk);
      io(IO_READ_OP, 8'h1d, 3'h0, 8'h00, 8'h00, 1'b0);
      u_iorsd_core_model.idle();
      results();
   end

endmodule : iorsd_top_tb
